// ==== core/pmsc_port_ctrl.sv ====
// port pin mode, pull-up, skip and routing control with an axi4-lite register slave
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
// Function
// - input kind bit: 0 analog, 1 digital
// - analog pin: pull-up, driver, receiver off
// - analog pin always reads back 0
// - push-pull bit 1 drives high and low
// - open-drain never drives high, releases on 1
// - undriven digital pin gets weak pull-up
// - pull-up off while driving low
// - global pull-up off bit kills all pull-ups
// - digital pin reads pad level, not latch
// - after reset hi-z with pull-up until enable
// - pin state readable whatever the routing
// - reserved pin never gets routed peripheral
// - routed functions only on unreserved pins
// - serial on pins 4/5, can on 6/7
// - port 4 digital only, no analog path
// - reserve bits only for ports 0 to 3
// - osc pins 2 and 3, reference pin 0
// - small variants share top pin with debug
// - matrix on bit in third route register
// - matrix off holds every driver off except the top pin while debug is active
// - two-wire bus channels forced open-drain
module pmsc_port_ctrl
    import pmsc_pkg::*;
#(
    parameter int PIN_COUNT = 40,
    parameter int NUM_CHAN  = 4
) (
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic [ADDR_W-1:0]    s_awaddr_i,
    input  wire logic                 s_awvalid_i,
    output logic                      s_awready_o,
    input  wire logic [DATA_W-1:0]    s_wdata_i,
    input  wire logic [3:0]           s_wstrb_i,
    input  wire logic                 s_wvalid_i,
    output logic                      s_wready_o,
    output logic [1:0]                s_bresp_o,
    output logic                      s_bvalid_o,
    input  wire logic                 s_bready_i,
    input  wire logic [ADDR_W-1:0]    s_araddr_i,
    input  wire logic                 s_arvalid_i,
    output logic                      s_arready_o,
    output logic [DATA_W-1:0]         s_rdata_o,
    output logic [1:0]                s_rresp_o,
    output logic                      s_rvalid_o,
    input  wire logic                 s_rready_i,
    input  wire logic [PIN_COUNT-1:0] pad_i,
    output logic [PIN_COUNT-1:0]      pad_o,
    output logic [PIN_COUNT-1:0]      pad_oe_o,
    output logic [PIN_COUNT-1:0]      pad_pullup_o,
    output logic [PIN_COUNT-1:0]      pad_rcv_en_o,
    output logic [PIN_COUNT-1:0]      pad_analog_o,
    input  wire logic                 serial_tx_i,
    output logic                      serial_rx_o,
    input  wire logic                 can_tx_i,
    output logic                      can_rx_o,
    input  wire logic [NUM_CHAN-1:0]  chan_out_i,
    output logic [NUM_CHAN-1:0]       chan_in_o,
    input  wire logic                 dbg_active_i,
    input  wire logic                 dbg_data_i,
    input  wire logic                 dbg_oe_i,
    output logic                      dbg_data_o,
    output logic                      vref_route_o,
    output logic                      osc_route_o
);

    localparam int CH_W = (NUM_CHAN > 1) ? $clog2(NUM_CHAN) : 1;
    localparam int DBG_PIN = PIN_COUNT - 1;
    localparam bit DBG_SHARED = (PIN_COUNT < MAX_PINS);

    if (!(PIN_COUNT == 40 || PIN_COUNT == 33 || PIN_COUNT == 25) ||
        NUM_CHAN < ODRAIN_CHANNELS || NUM_CHAN > 16) begin : g_bad_param
        $error("pmsc_port_ctrl: unsupported pin count or channel count");
    end

    // configuration storage
    logic [MAX_PINS-1:0]            latch_reg;
    logic [MAX_PINS-1:0]            kind_reg;
    logic [MAX_PINS-1:0]            drive_reg;
    logic [SKIP_PORTS*PORT_W-1:0]   reserve_reg;
    logic [PORT_W-1:0]              route1_reg;
    logic [PORT_W-1:0]              route2_reg;
    logic [PORT_W-1:0]              route3_reg;
    logic [PIN_COUNT-1:0]           sync1_reg;
    logic [PIN_COUNT-1:0]           sync2_reg;

    // bus slave state
    logic                awready_reg;
    logic                wready_reg;
    logic                aw_hold_reg;
    logic                w_hold_reg;
    logic [ADDR_W-1:0]   awaddr_reg;
    logic [PORT_W-1:0]   wdata_reg;
    logic                wstrb_reg;
    logic                bvalid_reg;
    logic [1:0]          bresp_reg;
    logic                arready_reg;
    logic                rvalid_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic [1:0]          rresp_reg;

    // pad derived state
    logic [MAX_PINS-1:0]  dig_full;
    logic [MAX_PINS-1:0]  skip_full;
    logic [PIN_COUNT-1:0] dig_w;
    logic [PIN_COUNT-1:0] skip_w;
    logic [PIN_COUNT-1:0] rd_w;
    logic                 matrix_on;
    logic                 pu_off;
    logic                 serial_en;
    logic                 can_en;
    logic [PIN_COUNT-1:0] out_val;
    logic [PIN_COUNT-1:0] is_input;
    logic [PIN_COUNT-1:0] force_od;
    logic [PIN_COUNT-1:0] routed;
    logic [CH_W-1:0]      chan_of [PIN_COUNT];
    logic [PIN_COUNT-1:0] drive_next;
    logic [PIN_COUNT-1:0] pullup_next;
    logic [NUM_CHAN-1:0]  chan_in_next;

    assign dig_full  = kind_reg | DIGITAL_ONLY_MASK;
    assign dig_w     = dig_full[PIN_COUNT-1:0];
    // port 4 has no reserve bits, so it always counts as unreserved
    assign skip_full = {{(MAX_PINS-SKIP_PORTS*PORT_W){1'b0}}, reserve_reg};
    assign skip_w    = skip_full[PIN_COUNT-1:0];
    assign rd_w      = sync2_reg & dig_w;
    assign matrix_on = route3_reg[ROUTE3_MATRIX_ON_BIT];
    assign pu_off    = route3_reg[ROUTE3_PULLUP_OFF_BIT];
    // fixed functions still yield to a reserved pin
    assign serial_en = route1_reg[ROUTE1_SERIAL_BIT] & matrix_on &
                       ~skip_w[SERIAL_TX_PIN] & ~skip_w[SERIAL_RX_PIN];
    assign can_en    = route1_reg[ROUTE1_CAN_BIT] & matrix_on &
                       ~skip_w[CAN_TX_PIN] & ~skip_w[CAN_RX_PIN];

    // routing: enabled channels in order take the lowest free pins
    always_comb begin
        int  cnt;
        logic found;
        cnt = 0;
        found = 1'b0;
        out_val  = latch_reg[PIN_COUNT-1:0];
        is_input = '0;
        force_od = '0;
        routed   = '0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            chan_of[i] = '0;
            if (serial_en && i == SERIAL_TX_PIN) begin
                out_val[i] = serial_tx_i;
            end else if (serial_en && i == SERIAL_RX_PIN) begin
                is_input[i] = 1'b1;
            end else if (can_en && i == CAN_TX_PIN) begin
                out_val[i] = can_tx_i;
            end else if (can_en && i == CAN_RX_PIN) begin
                is_input[i] = 1'b1;
            end else if (matrix_on && !skip_w[i]) begin
                found = 1'b0;
                for (int c = 0; c < NUM_CHAN; c++) begin
                    if (!found && c >= cnt && route2_reg[c]) begin
                        found = 1'b1;
                        cnt = c + 1;
                        routed[i] = 1'b1;
                        chan_of[i] = CH_W'(c);
                        out_val[i] = chan_out_i[c];
                        force_od[i] = (c < ODRAIN_CHANNELS);
                    end
                end
            end
        end
        // debug link borrows the top pin only while it is active
        if (DBG_SHARED && dbg_active_i) begin
            out_val[DBG_PIN]  = dbg_data_i;
            is_input[DBG_PIN] = ~dbg_oe_i;
            force_od[DBG_PIN] = 1'b0;
        end
    end

    // drive decision; open-drain only ever pulls low
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            drive_next[i] = matrix_on & dig_w[i] & ~is_input[i] &
                            ((drive_reg[i] & ~force_od[i]) | ~out_val[i]);
            if (DBG_SHARED && dbg_active_i && i == DBG_PIN) begin
                drive_next[i] = dig_w[i] & dbg_oe_i;
            end
        end
    end

    // pull-up only on undriven digital pins, never on a driven low
    assign pullup_next = dig_w & ~drive_next & {PIN_COUNT{~pu_off}};

    always_comb begin
        chan_in_next = '0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (routed[i] && chan_of[i] == CH_W'(c)) begin
                    chan_in_next[c] = rd_w[i];
                end
            end
        end
    end

    // pad side registers; sync1 is read only by sync2
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            pad_o        <= '0;
            pad_oe_o     <= '0;
            pad_pullup_o <= '1;
            pad_rcv_en_o <= '1;
            pad_analog_o <= '0;
        end else begin
            sync1_reg    <= pad_i;
            sync2_reg    <= sync1_reg;
            pad_o        <= out_val;
            pad_oe_o     <= drive_next;
            pad_pullup_o <= pullup_next;
            pad_rcv_en_o <= dig_w;
            pad_analog_o <= ~dig_w;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_rx_o  <= 1'b1;
            can_rx_o     <= 1'b1;
            chan_in_o    <= '0;
            dbg_data_o   <= 1'b0;
            vref_route_o <= 1'b0;
            osc_route_o  <= 1'b0;
        end else begin
            serial_rx_o  <= serial_en ? rd_w[SERIAL_RX_PIN] : 1'b1;
            can_rx_o     <= can_en ? rd_w[CAN_RX_PIN] : 1'b1;
            chan_in_o    <= chan_in_next;
            dbg_data_o   <= DBG_SHARED ? rd_w[DBG_PIN] : 1'b0;
            vref_route_o <= ~dig_w[VREF_PIN];
            osc_route_o  <= ~dig_w[OSC_IN_PIN] & ~dig_w[OSC_SECOND_PIN];
        end
    end

    // register bus decode
    logic [2:0]          w_rgn;
    logic [2:0]          w_port;
    logic [2:0]          r_rgn;
    logic [2:0]          r_port;
    logic                w_ok;
    logic                r_ok;
    logic                aw_fire;
    logic                w_fire;
    logic                do_write;
    logic                ar_fire;
    logic                b_fire;
    logic                r_fire;
    logic [MAX_PINS-1:0] rd_full;
    logic [PORT_W-1:0]   rd_byte;

    assign w_rgn    = awaddr_reg[RGN_MSB:RGN_LSB];
    assign w_port   = awaddr_reg[PORT_MSB:PORT_LSB];
    assign r_rgn    = s_araddr_i[RGN_MSB:RGN_LSB];
    assign r_port   = s_araddr_i[PORT_MSB:PORT_LSB];
    assign w_ok     = ((w_rgn == RGN_LATCH || w_rgn == RGN_KIND || w_rgn == RGN_DRIVE) &&
                       int'(w_port) < REG_PORTS) ||
                      (w_rgn == RGN_RESERVE && int'(w_port) < SKIP_PORTS) ||
                      (w_rgn == RGN_ROUTE && int'(w_port) < ROUTE_REGS);
    assign r_ok     = ((r_rgn == RGN_LATCH || r_rgn == RGN_KIND || r_rgn == RGN_DRIVE) &&
                       int'(r_port) < REG_PORTS) ||
                      (r_rgn == RGN_RESERVE && int'(r_port) < SKIP_PORTS) ||
                      (r_rgn == RGN_ROUTE && int'(r_port) < ROUTE_REGS);
    assign aw_fire  = s_awvalid_i & awready_reg;
    assign w_fire   = s_wvalid_i & wready_reg;
    assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign b_fire   = bvalid_reg & s_bready_i;
    assign ar_fire  = s_arvalid_i & arready_reg;
    assign r_fire   = rvalid_reg & s_rready_i;
    // pin-state reads come from the pad, independent of routing
    assign rd_full  = {{(MAX_PINS-PIN_COUNT){1'b0}}, rd_w};

    always_comb begin
        case (r_rgn)
            RGN_LATCH:   rd_byte = rd_full[int'(r_port)*PORT_W +: PORT_W];
            RGN_KIND:    rd_byte = dig_full[int'(r_port)*PORT_W +: PORT_W];
            RGN_DRIVE:   rd_byte = drive_reg[int'(r_port)*PORT_W +: PORT_W];
            RGN_RESERVE: rd_byte = (int'(r_port) < SKIP_PORTS) ?
                                   reserve_reg[int'(r_port[1:0])*PORT_W +: PORT_W] : '0;
            RGN_ROUTE:   rd_byte = (r_port == ROUTE_FIRST)  ? route1_reg :
                                   (r_port == ROUTE_SECOND) ? route2_reg :
                                   (r_port == ROUTE_THIRD)  ? route3_reg : '0;
            default:     rd_byte = '0;
        endcase
        if (!r_ok) begin
            rd_byte = '0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awready_reg <= 1'b0;
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_awaddr_i;
            end
            if (w_fire) begin
                wready_reg <= 1'b0;
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_wdata_i[PORT_W-1:0];
                wstrb_reg  <= s_wstrb_i[0];
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= w_ok ? RESP_OKAY : RESP_DECERR;
            end
            if (b_fire) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // narrow registers live in byte lane 0 only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch_reg   <= LATCH_RST;
            kind_reg    <= KIND_RST;
            drive_reg   <= DRIVE_RST;
            reserve_reg <= RESERVE_RST;
            route1_reg  <= ROUTE_RST;
            route2_reg  <= ROUTE_RST;
            route3_reg  <= ROUTE_RST;
        end else if (do_write && w_ok && wstrb_reg) begin
            case (w_rgn)
                RGN_LATCH:   latch_reg[int'(w_port)*PORT_W +: PORT_W] <= wdata_reg;
                RGN_KIND:    kind_reg[int'(w_port)*PORT_W +: PORT_W]  <= wdata_reg;
                RGN_DRIVE:   drive_reg[int'(w_port)*PORT_W +: PORT_W] <= wdata_reg;
                RGN_RESERVE: reserve_reg[int'(w_port[1:0])*PORT_W +: PORT_W] <= wdata_reg;
                RGN_ROUTE: begin
                    if (w_port == ROUTE_FIRST) begin
                        route1_reg <= wdata_reg;
                    end else if (w_port == ROUTE_SECOND) begin
                        route2_reg <= wdata_reg;
                    end else begin
                        route3_reg <= wdata_reg;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= {{(DATA_W-PORT_W){1'b0}}, rd_byte};
            rresp_reg   <= r_ok ? RESP_OKAY : RESP_DECERR;
        end else if (r_fire) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    assign s_awready_o = awready_reg;
    assign s_wready_o  = wready_reg;
    assign s_bvalid_o  = bvalid_reg;
    assign s_bresp_o   = bresp_reg;
    assign s_arready_o = arready_reg;
    assign s_rvalid_o  = rvalid_reg;
    assign s_rdata_o   = rdata_reg;
    assign s_rresp_o   = rresp_reg;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence pad_high_s;
        pad_i[0] ##1 pad_i[0];
    endsequence

    analog_drive_off_a: assert property ((pad_oe_o & ~$past(dig_w)) == '0)
        else $error("analog pin driven");
    analog_read_zero_a: assert property ((rd_w & ~dig_w) == '0)
        else $error("analog pin read nonzero");
    od_never_high_a: assert property (
        (pad_oe_o & pad_o & ~$past(drive_reg[PIN_COUNT-1:0] & ~force_od)) == '0)
        else $error("open-drain pin driven high");
    pullup_low_off_a: assert property ((pad_pullup_o & pad_oe_o & ~pad_o) == '0)
        else $error("pull-up on while driving low");
    global_pu_off_a: assert property ($past(pu_off) |-> pad_pullup_o == '0)
        else $error("pull-up on while globally off");
    matrix_off_hold_a: assert property (
        !$past(matrix_on) && !$past(dbg_active_i) |-> pad_oe_o == '0)
        else $error("driver on while matrix off");
    skip_no_route_a: assert property ((routed & skip_w) == '0)
        else $error("reserved pin routed");
    sync_read_a: assert property (pad_high_s ##1 dig_w[0] |-> rd_w[0])
        else $error("pad level not seen after sync");

endmodule

// ==== core/pmsc_pkg.sv ====
// constants shared by the port pin mode and skip control block
package pmsc_pkg;

    localparam int PORT_W      = 8;
    localparam int MAX_PINS    = 40;
    localparam int SKIP_PORTS  = 4;
    localparam int ANALOG_PORTS = 4;
    localparam int REG_PORTS   = 5;
    localparam int ROUTE_REGS  = 3;
    localparam int ODRAIN_CHANNELS = 2;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;

    // address layout: byte address = region * 0x20 + port * 4
    localparam int RGN_MSB  = 7;
    localparam int RGN_LSB  = 5;
    localparam int PORT_MSB = 4;
    localparam int PORT_LSB = 2;
    localparam logic [2:0] RGN_LATCH   = 3'h0;
    localparam logic [2:0] RGN_KIND    = 3'h1;
    localparam logic [2:0] RGN_DRIVE   = 3'h2;
    localparam logic [2:0] RGN_RESERVE = 3'h3;
    localparam logic [2:0] RGN_ROUTE   = 3'h4;

    // route select register indices and bits
    localparam logic [2:0] ROUTE_FIRST  = 3'h0;
    localparam logic [2:0] ROUTE_SECOND = 3'h1;
    localparam logic [2:0] ROUTE_THIRD  = 3'h2;
    localparam int ROUTE1_SERIAL_BIT    = 0;
    localparam int ROUTE1_CAN_BIT       = 1;
    localparam int ROUTE3_MATRIX_ON_BIT = 6;
    localparam int ROUTE3_PULLUP_OFF_BIT = 7;

    // fixed pin positions
    localparam int VREF_PIN       = 0;
    localparam int OSC_IN_PIN     = 2;
    localparam int OSC_SECOND_PIN = 3;
    localparam int SERIAL_TX_PIN  = 4;
    localparam int SERIAL_RX_PIN  = 5;
    localparam int CAN_TX_PIN     = 6;
    localparam int CAN_RX_PIN     = 7;

    // reset values
    localparam logic [MAX_PINS-1:0] LATCH_RST = {MAX_PINS{1'b1}};
    localparam logic [MAX_PINS-1:0] KIND_RST  = {MAX_PINS{1'b1}};
    localparam logic [MAX_PINS-1:0] DRIVE_RST = {MAX_PINS{1'b0}};
    localparam logic [SKIP_PORTS*PORT_W-1:0] RESERVE_RST = {(SKIP_PORTS*PORT_W){1'b0}};
    localparam logic [PORT_W-1:0] ROUTE_RST = 8'h00;

    // pins above the analog-capable ports have no analog path
    localparam logic [MAX_PINS-1:0] DIGITAL_ONLY_MASK =
        {{(MAX_PINS-ANALOG_PORTS*PORT_W){1'b1}}, {(ANALOG_PORTS*PORT_W){1'b0}}};

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ==== testbench/pmsc_pad_model.sv ====
// pad model: resolves each pad level from device drive, pull-up and an outside driver
`timescale 1ns/1ns
module pmsc_pad_model #(
    parameter int N = 40
) (
    input  wire logic         clk_i,
    input  wire logic [N-1:0] oe_i,
    input  wire logic [N-1:0] out_i,
    input  wire logic [N-1:0] pullup_i,
    input  wire logic [N-1:0] ext_en_i,
    input  wire logic [N-1:0] ext_val_i,
    output logic      [N-1:0] pad_o
);
    logic tog = 1'b0;
    // a floating pad toggles, so a stale level never passes for a pull-up
    always @(posedge clk_i) tog <= ~tog;
    assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~oe_i & ~ext_en_i & (pullup_i | {N{tog}}));
endmodule

// ==== testbench/port_pin_mode_and_skip_control_bench.sv ====
// self-checking bench for the port pin mode and skip control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module port_pin_mode_and_skip_control_bench;
    import pmsc_pkg::*;
    logic clk_i = 0, nrst_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, stx = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] br, rr;
    logic [39:0] pad, po, poe, ppu, prcv, pan, xen = 0, xval = 0;
    logic ctx = 0, srx, crx, dbgo, vro, oro;
    logic [3:0] cho = 0, chi;
    wire awr, wr_, bv, arr, rv;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int fails = 0, comparisons = 0;
    always #5 clk_i = ~clk_i;
    pmsc_port_ctrl #(.PIN_COUNT(40), .NUM_CHAN(4)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd),
        .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(wr_), .s_bresp_o(bresp),
        .s_bvalid_o(bv), .s_bready_i(bry), .s_araddr_i(ara), .s_arvalid_i(arv),
        .s_arready_o(arr), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rv),
        .s_rready_i(rry), .pad_i(pad), .pad_o(po), .pad_oe_o(poe), .pad_pullup_o(ppu),
        .pad_rcv_en_o(prcv), .pad_analog_o(pan), .serial_tx_i(stx), .serial_rx_o(srx),
        .can_tx_i(ctx), .can_rx_o(crx), .chan_out_i(cho), .chan_in_o(chi), .dbg_active_i(1'b0),
        .dbg_data_i(1'b0), .dbg_oe_i(1'b0), .dbg_data_o(dbgo), .vref_route_o(vro),
        .osc_route_o(oro));
    pmsc_pad_model #(.N(40)) pads (.clk_i(clk_i), .oe_i(poe), .out_i(po), .pullup_i(ppu),
        .ext_en_i(xen), .ext_val_i(xval), .pad_o(pad));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bry <= 1;
        do begin
            @(posedge clk_i);
            if (awv && awr) awv <= 0;
            if (wv && wr_) wv <= 0;
        end while (!bv);
        br = bresp;
        bry <= 0;
        cyc(3);
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk_i);
        ara <= a; arv <= 1; rry <= 1;
        do begin
            @(posedge clk_i);
            if (arv && arr) arv <= 0;
        end while (!rv);
        rd = rdata; rr = rresp;
        rry <= 0;
    endtask
    task automatic t_gate;
        `CHK("oe_reset", 40'h0, poe)
        `CHK("pu_reset", {40{1'b1}}, ppu)
        wr(8'h40, 8'hFF);
        wr(8'h00, 8'h0F);
        `CHK("oe_off", 8'h00, poe[7:0])
        rdr(8'h00);
        `CHK("rd_pulled", 32'hFF, rd)
        $display("test gate done");
    endtask
    task automatic t_push;
        wr(8'h88, 8'h40);
        `CHK("oe_pp", 8'hFF, poe[7:0])
        `CHK("out_pp", 8'h0F, po[7:0])
        `CHK("pu_pp", 8'h00, ppu[7:0])
        rdr(8'h00);
        `CHK("rd_pp", 32'h0F, rd)
        $display("test push-pull done");
    endtask
    task automatic t_odrain;
        wr(8'h04, 8'hF0);
        `CHK("oe_od", 8'h0F, poe[15:8])
        `CHK("out_od", 8'h00, po[15:8] & poe[15:8])
        `CHK("pu_od", 8'hF0, ppu[15:8])
        @(posedge clk_i) xen[12] <= 1;
        cyc(3);
        rdr(8'h04);
        `CHK("rd_od", 32'hE0, rd)
        wr(8'h88, 8'hC0);
        `CHK("pu_goff", 40'h0, ppu)
        wr(8'h88, 8'h40);
        $display("test open-drain done");
    endtask
    task automatic t_analog;
        wr(8'h28, 8'h00);
        `CHK("an_on", 8'hFF, pan[23:16])
        `CHK("an_off", 24'h0, {poe[23:16], ppu[23:16], prcv[23:16]})
        rdr(8'h08);
        `CHK("rd_an", 32'h0, rd)
        wr(8'h30, 8'h00);
        rdr(8'h30);
        `CHK("p4_kind", 32'hFF, rd)
        `CHK("p4_an", 8'h00, pan[39:32])
        $display("test analog done");
    endtask
    task automatic t_route;
        wr(8'h80, 8'h01);
        @(posedge clk_i) stx <= 1;
        cyc(2);
        `CHK("tx_pin", 2'b11, {poe[4], po[4]})
        wr(8'h60, 8'h10);
        `CHK("tx_skip", 2'b10, {poe[4], po[4]})
        wr(8'h64, 8'h5A);
        rdr(8'h64);
        `CHK("rsv_rd", 32'h5A, rd)
        wr(8'h70, 8'h01);
        `CHK("p4_rsv_w", RESP_DECERR, br)
        rdr(8'h70);
        `CHK("p4_rsv_r", {RESP_DECERR, 32'h0}, {rr, rd})
        $display("test routing done");
    endtask
    task automatic t_chan;
        wr(8'h60, 8'h01);
        wr(8'h80, 8'h03);
        wr(8'h84, 8'h0D);
        @(posedge clk_i);
        cho <= 4'h5;
        ctx <= 1;
        xen[7:5] <= 3'b101;
        cyc(5);
        `CHK("chan_pins", 6'b110011, {poe[3:1], po[3:1]})
        `CHK("chan_od", 1'b0, poe[1])
        `CHK("chan_in", 4'h5, chi)
        `CHK("can_tx", 2'b11, {poe[6], po[6]})
        `CHK("rx_pins", 2'b00, {srx, crx})
        wr(8'h20, 8'hF2);
        `CHK("fixed_an", 3'b110, {vro, oro, dbgo})
        $display("test channels done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(12);
        nrst_i <= 1;
        cyc(2);
        t_gate;
        t_push;
        t_odrain;
        t_analog;
        t_route;
        t_chan;
        report_and_stop;
    end
    initial begin
        #100000;
        fails++;
        report_and_stop;
    end
endmodule
